// File: src/rsfo_pkg.sv
`default_nettype none
package rsfo_pkg;
    // opcode fields
    localparam logic [5:0] RSFO_ROT_OPC = 6'h10;   // 0100 00
    localparam logic [6:0] RSFO_SET_OPC = 7'h34;   // 0110 100
    localparam int RSFO_ROT_OPC_MSB = 15;
    localparam int RSFO_ROT_OPC_LSB = 10;
    localparam int RSFO_SET_OPC_LSB = 9;
    localparam int RSFO_D_BIT = 9;
    localparam int RSFO_A_BIT = 8;
    localparam logic [7:0] RSFO_ALL_ONES = 8'hff;
    localparam logic [7:0] RSFO_ILO_LIMIT = 8'h5f;
    // access bank upper half sits in bank 15
    localparam logic [3:0] RSFO_ACC_HI_BANK = 4'hf;
    localparam logic [3:0] RSFO_ACC_LO_BANK = 4'h0;
    localparam logic [7:0] RSFO_ZERO8 = 8'h00;
    localparam logic [11:0] RSFO_ZERO12 = 12'h000;
    localparam logic [3:0] RSFO_ZERO4 = 4'h0;
    localparam int RSFO_DATA_W = 8;
    // file address bit that splits the access bank into its low and high halves
    localparam int RSFO_ACC_SPLIT_BIT = 7;

    typedef enum logic [1:0] {RSFO_Q1, RSFO_Q2, RSFO_Q3, RSFO_Q4} rsfo_phase_e;
endpackage
`default_nettype wire

// File: src/rsfo_dec_if.sv
`default_nettype none
interface rsfo_dec_if;
    logic [15:0] word;
    logic is_rot;
    logic is_set;
    logic dest_file;
    logic bank_mode;
    logic [7:0] faddr;
    modport dec (input word, output is_rot, is_set, dest_file, bank_mode, faddr);
    modport core (output word, input is_rot, is_set, dest_file, bank_mode, faddr);
endinterface
`default_nettype wire

// File: src/rsfo_decode.sv
`default_nettype none
module rsfo_decode
    import rsfo_pkg::*;
(
    rsfo_dec_if.dec d
);
    always_comb begin
        // RQ5: rotate opcode match
        d.is_rot = (d.word[RSFO_ROT_OPC_MSB:RSFO_ROT_OPC_LSB] == RSFO_ROT_OPC);
        // RQ8: set-file opcode match
        d.is_set = (d.word[RSFO_ROT_OPC_MSB:RSFO_SET_OPC_LSB] == RSFO_SET_OPC);
        // RQ2: destination select bit
        d.dest_file = d.is_set | d.word[RSFO_D_BIT];
        d.bank_mode = d.word[RSFO_A_BIT];
        d.faddr = d.word[7:0];
    end
endmodule
`default_nettype wire

// File: src/rsfo_core.sv
`default_nettype none
// How it works
// RQ1: rotate right by one, old bit 0 goes to bit 7.
// RQ2: destination bit 0 writes working register, 1 writes file register.
// RQ3: bank bit 0 uses access bank, 1 uses bank select register.
// RQ4: bank bit 0, extended set, address up to 95: indexed literal offset.
// RQ5: rotate decoded from 0100 00da ffff ffff; updates negative and zero.
// RQ6: set-file writes all ones into the addressed file register.
// RQ7: one cycle of four phases: decode, read, process, write.
// RQ8: set-file decoded from 0110 100a ffff ffff; flags unchanged.
module rsfo_core
    import rsfo_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    // instruction and mode
    input wire logic [15:0] INSTR_I,
    input wire logic EXT_SET_EN_I,
    input wire logic [3:0] BANK_SELECT_REGISTER_I,
    input wire logic [11:0] INDEX_BASE_I,
    input wire logic [7:0] WREG_I,
    // file read and write port
    input wire logic [7:0] FILE_RDATA_I,
    output logic [11:0] FILE_ADDR_O,
    output logic FILE_RD_O,
    output logic FILE_WR_O,
    output logic [7:0] FILE_WDATA_O,
    // working register and flags
    output logic WREG_WR_O,
    output logic [7:0] WREG_WDATA_O,
    output logic FLAG_WR_O,
    output logic NEG_FLAG_O,
    output logic ZERO_FLAG_O,
    // status
    output logic [1:0] PHASE_O,
    output logic INSTR_DONE_O
);
    typedef struct packed {
        rsfo_phase_e phase;
        logic is_rot;
        logic is_set;
        logic dest_file;
        logic [11:0] addr;
        logic [7:0] result;
        logic rd;
        logic fwr;
        logic wwr;
        logic flg;
        logic neg;
        logic zero;
        logic done;
    } rsfo_state_s;

    rsfo_state_s st_reg;
    rsfo_state_s st_next;
    rsfo_dec_if dif ();

    // decoded operation
    logic op_rot;
    logic op_set;

    // address candidates
    logic use_banked;
    logic in_window;
    logic use_indexed;
    logic [3:0] access_bank;
    logic [11:0] banked_addr;
    logic [11:0] indexed_addr;
    logic [11:0] access_addr;
    logic [11:0] resolved_addr;

    // data path
    logic [7:0] rot_val;
    logic [7:0] bit_clear;
    logic rot_neg;
    logic rot_zero;
    logic [7:0] op_result;

    // last-phase write enables
    logic file_wr_en;
    logic wreg_wr_en;
    logic flag_wr_en;

    assign dif.word = INSTR_I;

    rsfo_decode u_dec (
        .d(dif)
    );

    assign op_rot = dif.is_rot;
    assign op_set = dif.is_set;

    // RQ3: bank bit picks the banked path
    assign use_banked = dif.bank_mode;
    assign banked_addr = {BANK_SELECT_REGISTER_I, dif.faddr};

    // RQ4: low window, extended set, no bank
    assign in_window = (dif.faddr <= RSFO_ILO_LIMIT);
    assign use_indexed = ~dif.bank_mode & EXT_SET_EN_I & in_window;
    // wraps at 12 bits like the file space, no carry out kept
    assign indexed_addr = INDEX_BASE_I + {RSFO_ZERO4, dif.faddr};

    // RQ3: access bank split low/high
    assign access_bank = dif.faddr[RSFO_ACC_SPLIT_BIT] ? RSFO_ACC_HI_BANK : RSFO_ACC_LO_BANK;
    assign access_addr = {access_bank, dif.faddr};

    // banked wins, then indexed, then the plain access bank
    assign resolved_addr = use_banked ? banked_addr : (use_indexed ? indexed_addr : access_addr);

    // RQ1: bit n takes bit n+1, top bit takes old bit 0
    for (genvar n = 0; n < RSFO_DATA_W; n++) begin : g_bit
        if (n == RSFO_DATA_W - 1) begin : g_wrap
            assign rot_val[n] = FILE_RDATA_I[0];
        end else begin : g_shift
            assign rot_val[n] = FILE_RDATA_I[n + 1];
        end
        assign bit_clear[n] = ~rot_val[n];
    end

    // RQ5: negative is the result's top bit, zero when every bit is clear
    assign rot_neg = rot_val[RSFO_DATA_W - 1];
    assign rot_zero = &bit_clear;

    // RQ6: set-file ignores the read data
    assign op_result = st_reg.is_rot ? rot_val : RSFO_ALL_ONES;

    // RQ2: rotate follows the destination bit, set-file always to the file
    assign file_wr_en = (st_reg.is_rot | st_reg.is_set) & st_reg.dest_file;
    assign wreg_wr_en = st_reg.is_rot & ~st_reg.dest_file;
    // RQ8: only the rotate touches the flags
    assign flag_wr_en = st_reg.is_rot;

    always_comb begin
        st_next = st_reg;
        st_next.rd = 1'b0;
        st_next.fwr = 1'b0;
        st_next.wwr = 1'b0;
        st_next.flg = 1'b0;
        st_next.done = 1'b0;
        // RQ7: four phase sequence
        unique case (st_reg.phase)
            RSFO_Q1: begin
                st_next.phase = RSFO_Q2;
                st_next.is_rot = op_rot;
                st_next.is_set = op_set;
                st_next.dest_file = dif.dest_file;
                // RQ3: address resolved before the read phase
                st_next.addr = resolved_addr;
                // only the rotate needs the file read
                st_next.rd = op_rot;
            end
            RSFO_Q2: begin
                st_next.phase = RSFO_Q3;
            end
            RSFO_Q3: begin
                st_next.phase = RSFO_Q4;
                // result and strobes land in Q4
                st_next.result = op_result;
                st_next.fwr = file_wr_en;
                st_next.wwr = wreg_wr_en;
                st_next.flg = flag_wr_en;
                // flags hold unless a rotate writes them
                if (flag_wr_en) begin
                    st_next.neg = rot_neg;
                    st_next.zero = rot_zero;
                end
            end
            RSFO_Q4: begin
                st_next.phase = RSFO_Q1;
                st_next.done = st_reg.is_rot | st_reg.is_set;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            st_reg <= '{phase: RSFO_Q1, addr: RSFO_ZERO12, result: RSFO_ZERO8, default: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // file port; read data must stand in Q3 and is taken on the edge leaving it
    assign FILE_ADDR_O = st_reg.addr;
    assign FILE_RD_O = st_reg.rd;
    assign FILE_WR_O = st_reg.fwr;
    assign FILE_WDATA_O = st_reg.result;

    // working register and flags; flags hold between rotates
    assign WREG_WR_O = st_reg.wwr;
    assign WREG_WDATA_O = st_reg.result;
    assign FLAG_WR_O = st_reg.flg;
    assign NEG_FLAG_O = st_reg.neg;
    assign ZERO_FLAG_O = st_reg.zero;

    // status
    assign PHASE_O = st_reg.phase;
    assign INSTR_DONE_O = st_reg.done;
endmodule
`default_nettype wire

// File: verif/rsfo_core_checker.sv
`default_nettype none
module rsfo_core_checker (
    // watched ports
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    input wire logic [7:0] FILE_RDATA_I,
    input wire logic FILE_RD_O,
    input wire logic FILE_WR_O,
    input wire logic [7:0] FILE_WDATA_O,
    input wire logic WREG_WR_O,
    input wire logic FLAG_WR_O,
    input wire logic NEG_FLAG_O,
    input wire logic ZERO_FLAG_O,
    input wire logic [1:0] PHASE_O,
    input wire logic INSTR_DONE_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    logic [7:0] rd_reg;
    always_ff @(posedge REF_CLK_I)
        if (PHASE_O == 2'h2)
            rd_reg <= FILE_RDATA_I;
    AST_ROT_DATA: assert property (FILE_RD_O |-> ##2 FILE_WDATA_O == {rd_reg[0], rd_reg[7:1]})
        else $error("bad rotate data");
    AST_ROT_DEST: assert property (FILE_RD_O |-> ##2 (FILE_WR_O ^ WREG_WR_O) && FLAG_WR_O)
        else $error("bad rotate target");
    AST_ROT_FLAGS: assert property (FILE_RD_O |-> ##2 NEG_FLAG_O == rd_reg[0] && ZERO_FLAG_O == (rd_reg == 8'h00))
        else $error("bad rotate flags");
    AST_SET_DATA: assert property (FILE_WR_O && !FLAG_WR_O |-> FILE_WDATA_O == 8'hff)
        else $error("bad set data");
    AST_SET_FLAGS: assert property (FILE_WR_O && !FLAG_WR_O |-> $stable(NEG_FLAG_O) && $stable(ZERO_FLAG_O))
        else $error("set touched flags");
    AST_PHASE_STEP: assert property (RESET_N_I |=> PHASE_O == $past(PHASE_O) + 2'h1)
        else $error("bad phase step");
    AST_WR_IN_Q4: assert property (FILE_WR_O || WREG_WR_O || FLAG_WR_O |-> PHASE_O == 2'h3)
        else $error("write outside last phase");
    AST_DONE_NEXT: assert property (FILE_WR_O || WREG_WR_O |=> INSTR_DONE_O && PHASE_O == 2'h0)
        else $error("missing done");
    cover property (FILE_RD_O ##2 WREG_WR_O);
    cover property (FILE_RD_O ##2 FILE_WR_O);
    cover property (FILE_WR_O && !FLAG_WR_O);
endmodule
bind rsfo_core rsfo_core_checker u_chk (.*);
`default_nettype wire

// File: verif/test_rsfo_core.sv
`default_nettype none
module test_rsfo_core;
    timeunit 1ns;
    timeprecision 100ps;
    // f = read, flag write, file write, w write, negative, zero
    typedef struct {logic [15:0] i; logic e; logic [3:0] b; logic [11:0] x; logic [7:0] r;
        logic [11:0] a; logic [7:0] w; logic [5:0] f;} rsfo_row_s;
    logic REF_CLK_I = 1'h0, RESET_N_I = 1'h0, EXT_SET_EN_I = 1'h0;
    logic [15:0] INSTR_I = 16'h0000;
    logic [3:0] BANK_SELECT_REGISTER_I = 4'h0;
    logic [11:0] INDEX_BASE_I = 12'h000, FILE_ADDR_O;
    logic [7:0] WREG_I = 8'h00, FILE_RDATA_I = 8'h00, FILE_WDATA_O, WREG_WDATA_O;
    logic FILE_RD_O, FILE_WR_O, WREG_WR_O, FLAG_WR_O, NEG_FLAG_O, ZERO_FLAG_O, INSTR_DONE_O;
    logic [1:0] PHASE_O;
    int mismatches = 0, total_checks = 0;
    rsfo_row_s rows [7] = '{
        '{16'h4210, 1'h1, 4'h0, 12'h200, 8'hd7, 12'h210, 8'heb, 6'h3a},
        '{16'h685f, 1'h1, 4'h0, 12'h100, 8'h00, 12'h15f, 8'hff, 6'h0a},
        '{16'h4090, 1'h0, 4'h0, 12'h000, 8'h00, 12'hf90, 8'h00, 6'h35},
        '{16'h6960, 1'h1, 4'h2, 12'h100, 8'h00, 12'h260, 8'hff, 6'h09},
        '{16'h6860, 1'h1, 4'h0, 12'h100, 8'h00, 12'h060, 8'hff, 6'h09},
        '{16'h4380, 1'h0, 4'h3, 12'h000, 8'h01, 12'h380, 8'h80, 6'h3a},
        '{16'h0000, 1'h1, 4'h0, 12'h000, 8'h00, 12'h000, 8'h00, 6'h02}};
    rsfo_core dut (.*);
    always #12.5 REF_CLK_I = ~REF_CLK_I;
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one instruction cycle, entered at the edge before the taking edge
    task automatic run(input rsfo_row_s t);
        INSTR_I <= t.i;
        EXT_SET_EN_I <= t.e;
        BANK_SELECT_REGISTER_I <= t.b;
        INDEX_BASE_I <= t.x;
        @(posedge REF_CLK_I) #1;
        if (t.f[3:2] != 2'h0) check(FILE_ADDR_O, t.a);
        check({11'h000, FILE_RD_O}, {11'h000, t.f[5]});
        @(posedge REF_CLK_I) FILE_RDATA_I <= t.r;
        @(posedge REF_CLK_I) #1;
        check({7'h00, FLAG_WR_O, FILE_WR_O, WREG_WR_O, NEG_FLAG_O, ZERO_FLAG_O}, {7'h00, t.f[4:0]});
        if (t.f[3:2] != 2'h0) check({4'h0, t.f[3] ? FILE_WDATA_O : WREG_WDATA_O}, {4'h0, t.w});
        @(posedge REF_CLK_I);
        $display("row %h done", t.i);
    endtask
    initial begin
        repeat (5) @(posedge REF_CLK_I);
        RESET_N_I <= 1'h1;
        foreach (rows[k]) run(rows[k]);
        // reset lands in mid-instruction
        INSTR_I <= 16'h4210;
        @(posedge REF_CLK_I);
        RESET_N_I <= 1'h0;
        repeat (2) @(posedge REF_CLK_I);
        #1 check({7'h00, PHASE_O, FILE_WR_O, NEG_FLAG_O, ZERO_FLAG_O}, 12'h000);
        // second release: the next word must be taken cleanly
        @(posedge REF_CLK_I);
        RESET_N_I <= 1'h1;
        run(rows[0]);
        $display("reset test done");
        finish_test();
    end
    initial begin
        repeat (100) @(posedge REF_CLK_I);
        mismatches++;
        finish_test();
    end
endmodule
`default_nettype wire
